// ==== logic/aas_regs.svh ====
// register offsets, field positions, reset values and counts of the arm sequencer
`ifndef AAS_REGS_SVH
`define AAS_REGS_SVH
`define AAS_OFS_CTRL     8'h00
`define AAS_OFS_CMD      8'h04
`define AAS_OFS_STATUS   8'h08
`define AAS_OFS_PLIMIT   8'h0C
`define AAS_OFS_PCOUNT   8'h10
`define AAS_OFS_CURSOR   8'h14
`define AAS_OFS_CHMASK   8'h18
`define AAS_OFS_TOD      8'h1C
`define AAS_OFS_ATIME    8'h20
`define AAS_OFS_MADDR    8'h24
`define AAS_OFS_MDATA    8'h28
`define AAS_CMD_ARM      0
`define AAS_CMD_ADVANCE  1
`define AAS_CMD_MOVESTOP 2
`define AAS_CMD_STOP     3
`define AAS_CMD_COPYAB   4
`define AAS_CMD_SNAP     5
`define AAS_CTRL_MODE_LO 0
`define AAS_CTRL_END_LO  4
`define AAS_CUR_REF_LO   16
`define AAS_MADDR_SEL_LO 16
`define AAS_LEVEL_FILL   4'hF
`define AAS_LEVEL_FIRST  4'h0
`define AAS_PASS_MAX     14'h270F
`define AAS_END_RESET    4'hF
`endif

// ==== logic/aas_pkg.sv ====
// types shared by the acquisition arm sequencer
package aas_pkg;
	typedef enum logic [2:0] {
		AAS_MANUAL      = 3'h0,
		AAS_AUTO        = 3'h1,
		AAS_STOP_EQ     = 3'h2,
		AAS_STOP_NE     = 3'h3,
		AAS_STOP_EQ_LIM = 3'h4,
		AAS_STOP_NE_LIM = 3'h5
	} aas_mode_e;
	typedef enum logic [1:0] {
		AAS_SEL_M   = 2'h0,
		AAS_SEL_A   = 2'h1,
		AAS_SEL_B   = 2'h2,
		AAS_SEL_LVL = 2'h3
	} aas_sel_e;
	typedef enum logic [2:0] {
		AAS_ST_IDLE, AAS_ST_CLEAR, AAS_ST_WAIT, AAS_ST_REC,
		AAS_ST_XFER, AAS_ST_POST, AAS_ST_CMP, AAS_ST_DECIDE
	} aas_state_e;
endpackage

// ==== logic/aas_acq_arm_seq.sv ====
// acquisition arm sequencer: arming, re-arm, pass count and compare stop
//
// Chosen here: the APB interface to the registers and the address map.
`include "aas_regs.svh"

// What this block does
// - manual mode: one cycle per arm, then halt
// - auto mode re-arms after every completed cycle until a nonzero pass limit is reached
// - re-armed cycles reuse the parameters latched at arm
// - re-arm zeroes memory M, level tags to F
// - first valid clock after arm enters level 0
// - pass limit 0 to 9999, zero disables
// - arm clears pass count and restarts, even armed
// - stop when completed passes reach nonzero limit
// - move-stop halts and transfers; stop only halts
// - advance command forces the next level
// - cycle ends on stop condition or end-level exit
// - report level with busy or ready status
// - pass count read as snapshot, kept until arm
// - full compare A with B, stop on match
// - compare modes honour pass limit and stops
// - within limits compares only displayed channels
// - within limits covers control through reference cursor
// - reference before control covers whole memory
// - A holds last full pass, M partial
// - B loadable by edit, port or copy
// - store time of day with each recording
// - advance out of end level ends; jump not
module aas_acq_arm_seq
	import aas_pkg::*;
#(
	parameter int CH    = 32,
	parameter int AW    = 8,
	parameter int DEPTH = 256
) (
	// clock and reset
	input  wire logic          clock,
	input  wire logic          rst_b,
	// apb slave
	input  wire logic          psel,
	input  wire logic          penable,
	input  wire logic          pwrite,
	input  wire logic [7:0]    paddr,
	input  wire logic [31:0]   pwdata,
	output logic      [31:0]   prdata,
	output logic               pready,
	output logic               pslverr,
	// sampled target and level condition results
	input  wire logic          sample_valid,
	input  wire logic [CH-1:0] sample_data,
	input  wire logic          cond_stop,
	input  wire logic          cond_jump,
	input  wire logic [3:0]    jump_level,
	input  wire logic          cond_advance,
	input  wire logic          cond_trace,
	// status toward the display
	output logic      [3:0]    level_out,
	output logic               busy_out,
	output logic               ready_out
);
	generate
		if (CH < 1 || CH > 32 || AW < 1 || AW > 16 || DEPTH != (1 << AW)) begin : g_bad
			$error("aas_acq_arm_seq: unsupported CH, AW or DEPTH");
		end
	endgenerate
	localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);
	// memories: trace M, display A, reference B, level tags of M
	logic [CH-1:0]    mem_m [DEPTH];
	logic [CH-1:0]    mem_a [DEPTH];
	logic [CH-1:0]    mem_b [DEPTH];
	logic [3:0]       mem_lvl [DEPTH];
	// software registers
	aas_mode_e        mode_reg;
	logic [3:0]       end_level_reg;
	logic [13:0]      plimit_reg;
	logic [AW-1:0]    cur_ctrl_reg;
	logic [AW-1:0]    cur_ref_reg;
	logic [CH-1:0]    chmask_reg;
	logic [31:0]      tod_reg;
	logic [31:0]      atime_reg;
	logic [13:0]      psnap_reg;
	logic [AW-1:0]    maddr_reg;
	aas_sel_e         msel_reg;
	// run state
	aas_state_e       state_reg;
	aas_mode_e        run_mode_reg;
	logic [3:0]       run_end_reg;
	logic [13:0]      run_limit_reg;
	logic [AW-1:0]    run_lo_reg;
	logic [AW-1:0]    run_hi_reg;
	logic [CH-1:0]    run_mask_reg;
	logic [3:0]       level_reg;
	logic [AW-1:0]    ptr_reg;
	logic [AW-1:0]    wptr_reg;
	logic             mfull_reg;
	logic             halt_after_reg;
	logic             mismatch_reg;
	logic [13:0]      pcount_reg;
	logic             copy_busy_reg;
	logic [AW-1:0]    cptr_reg;
	// bus decode
	logic             apb_wr;
	logic             apb_rd;
	logic             cmd_wr;
	logic             arm_cmd;
	logic             adv_cmd;
	logic             mvstop_cmd;
	logic             stop_cmd;
	logic             cmp_hit;
	logic             limit_hit;
	logic             last_diff;
	// masked difference of two samples, used by compare stepping
	function automatic logic differs(input logic [CH-1:0] x, input logic [CH-1:0] y,
			input logic [CH-1:0] m);
		differs = |((x ^ y) & m);
	endfunction
	// is this a mode that compares A against B
	function automatic logic is_cmp(input aas_mode_e md);
		is_cmp = (md != AAS_MANUAL) && (md != AAS_AUTO);
	endfunction
	// a transfer completes at the edge where pready is seen high
	assign apb_wr     = psel & penable & pready & pwrite;
	assign apb_rd     = psel & penable & ~pready & ~pwrite;
	assign cmd_wr     = apb_wr && (paddr == `AAS_OFS_CMD);
	assign arm_cmd    = cmd_wr & pwdata[`AAS_CMD_ARM];
	assign adv_cmd    = cmd_wr & pwdata[`AAS_CMD_ADVANCE];
	assign mvstop_cmd = cmd_wr & pwdata[`AAS_CMD_MOVESTOP];
	assign stop_cmd   = cmd_wr & pwdata[`AAS_CMD_STOP];
	assign last_diff  = differs(mem_a[ptr_reg], mem_b[ptr_reg], run_mask_reg);
	// equal modes stop on no mismatch, unequal modes on any mismatch
	assign cmp_hit    = (run_mode_reg == AAS_STOP_NE || run_mode_reg == AAS_STOP_NE_LIM)
		? mismatch_reg : ~mismatch_reg;
	assign limit_hit  = (run_limit_reg != 14'h0000) && (pcount_reg >= run_limit_reg);
	// apb handshake: one wait cycle, so every answer comes from a flop
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready && (paddr > `AAS_OFS_MDATA || paddr[1:0] != 2'h0);
		end
	end
	// read data, captured in the wait cycle and held with pready
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			prdata <= 32'h0000_0000;
		end else if (apb_rd) begin
			prdata <= 32'h0000_0000;
			unique case (paddr)
				`AAS_OFS_CTRL:   prdata <= {24'h00_0000, end_level_reg, 1'b0, mode_reg};
				`AAS_OFS_STATUS: prdata <= {24'h00_0000, level_reg, 1'b0,
					state_reg == AAS_ST_IDLE, busy_out, copy_busy_reg};
				`AAS_OFS_PLIMIT: prdata <= {18'h0_0000, plimit_reg};
				`AAS_OFS_PCOUNT: prdata <= {18'h0_0000, psnap_reg};
				`AAS_OFS_CURSOR: prdata <= {16'(cur_ref_reg), 16'(cur_ctrl_reg)};
				`AAS_OFS_CHMASK: prdata <= 32'(chmask_reg);
				`AAS_OFS_TOD:    prdata <= tod_reg;
				`AAS_OFS_ATIME:  prdata <= atime_reg;
				`AAS_OFS_MADDR:  prdata <= {14'h0000, msel_reg, 16'(maddr_reg)};
				`AAS_OFS_MDATA: begin
					unique case (msel_reg)
						AAS_SEL_M:   prdata <= 32'(mem_m[maddr_reg]);
						AAS_SEL_A:   prdata <= 32'(mem_a[maddr_reg]);
						AAS_SEL_B:   prdata <= 32'(mem_b[maddr_reg]);
						AAS_SEL_LVL: prdata <= 32'(mem_lvl[maddr_reg]);
					endcase
				end
				default:         prdata <= 32'h0000_0000;
			endcase
		end
	end
	// writable configuration; pass limit writes above the maximum are ignored
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			mode_reg      <= AAS_MANUAL;
			end_level_reg <= `AAS_END_RESET;
			plimit_reg    <= 14'h0000;
			cur_ctrl_reg  <= '0;
			cur_ref_reg   <= '0;
			chmask_reg    <= '1;
			maddr_reg     <= '0;
			msel_reg      <= AAS_SEL_A;
		end else if (apb_wr) begin
			if (paddr == `AAS_OFS_CTRL && pwdata[2:0] <= 3'(AAS_STOP_NE_LIM))
				mode_reg <= aas_mode_e'(pwdata[`AAS_CTRL_MODE_LO +: 3]);
			if (paddr == `AAS_OFS_CTRL)
				end_level_reg <= pwdata[`AAS_CTRL_END_LO +: 4];
			if (paddr == `AAS_OFS_PLIMIT && pwdata[13:0] <= `AAS_PASS_MAX && pwdata[31:14] == '0)
				plimit_reg <= pwdata[13:0];
			if (paddr == `AAS_OFS_CURSOR) begin
				cur_ctrl_reg <= pwdata[AW-1:0];
				cur_ref_reg  <= pwdata[`AAS_CUR_REF_LO +: AW];
			end
			if (paddr == `AAS_OFS_CHMASK)
				chmask_reg <= pwdata[CH-1:0];
			if (paddr == `AAS_OFS_MADDR) begin
				maddr_reg <= pwdata[AW-1:0];
				msel_reg  <= aas_sel_e'(pwdata[`AAS_MADDR_SEL_LO +: 2]);
			end
		end
	end
	// time of day holds what software writes; the time tag follows each transfer
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			tod_reg   <= 32'h0000_0000;
			atime_reg <= 32'h0000_0000;
		end else begin
			if (apb_wr && paddr == `AAS_OFS_TOD)
				tod_reg <= pwdata;
			if (state_reg == AAS_ST_XFER && ptr_reg == LAST_IDX)
				atime_reg <= tod_reg;
		end
	end
	// pass count: cleared by arm, bumped once per pass in the post step (not after move-stop), snapshot on demand
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			pcount_reg <= 14'h0000;
			psnap_reg  <= 14'h0000;
		end else begin
			if (arm_cmd) begin
				pcount_reg <= 14'h0000;
				psnap_reg  <= 14'h0000;
			end else begin
				if (state_reg == AAS_ST_POST && pcount_reg != `AAS_PASS_MAX)
					pcount_reg <= pcount_reg + 14'h0001;
				if (cmd_wr && pwdata[`AAS_CMD_SNAP])
					psnap_reg <= pcount_reg;
			end
		end
	end
	// main sequencer: arm, clear, wait for clock, record, transfer, compare, decide
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			state_reg      <= AAS_ST_IDLE;
			run_mode_reg   <= AAS_MANUAL;
			run_end_reg    <= `AAS_END_RESET;
			run_limit_reg  <= 14'h0000;
			run_lo_reg     <= '0;
			run_hi_reg     <= '0;
			run_mask_reg   <= '0;
			level_reg      <= `AAS_LEVEL_FILL;
			ptr_reg        <= '0;
			wptr_reg       <= '0;
			mfull_reg      <= 1'b0;
			halt_after_reg <= 1'b0;
			mismatch_reg   <= 1'b0;
		end else if (arm_cmd) begin
			// parameters latched here stay fixed for every re-armed pass
			state_reg      <= AAS_ST_CLEAR;
			run_mode_reg   <= mode_reg;
			run_end_reg    <= end_level_reg;
			run_limit_reg  <= plimit_reg;
			halt_after_reg <= 1'b0;
			ptr_reg        <= '0;
			if (mode_reg == AAS_STOP_EQ_LIM || mode_reg == AAS_STOP_NE_LIM) begin
				run_mask_reg <= chmask_reg;
				if (cur_ref_reg < cur_ctrl_reg) begin
					run_lo_reg <= '0;
					run_hi_reg <= LAST_IDX;
				end else begin
					run_lo_reg <= cur_ctrl_reg;
					run_hi_reg <= cur_ref_reg;
				end
			end else begin
				run_mask_reg <= '1;
				run_lo_reg   <= '0;
				run_hi_reg   <= LAST_IDX;
			end
		end else if (stop_cmd && state_reg != AAS_ST_IDLE) begin
			state_reg <= AAS_ST_IDLE;
		end else if (mvstop_cmd && state_reg != AAS_ST_IDLE) begin
			halt_after_reg <= 1'b1; // a pass already in A needs no second move
			if (state_reg == AAS_ST_CLEAR || state_reg == AAS_ST_WAIT || state_reg == AAS_ST_REC) begin
				state_reg <= AAS_ST_XFER;
				ptr_reg   <= '0;
			end else if (state_reg != AAS_ST_XFER) begin
				state_reg <= AAS_ST_IDLE;
			end
		end else begin
			unique case (state_reg)
				AAS_ST_IDLE: ;
				AAS_ST_CLEAR: begin
					ptr_reg <= ptr_reg + 1'b1;
					if (ptr_reg == LAST_IDX) begin
						state_reg <= AAS_ST_WAIT;
						level_reg <= `AAS_LEVEL_FILL;
						wptr_reg  <= '0;
						mfull_reg <= 1'b0;
					end
				end
				AAS_ST_WAIT: begin
					if (sample_valid) begin
						state_reg <= AAS_ST_REC;
						level_reg <= `AAS_LEVEL_FIRST;
					end
				end
				AAS_ST_REC: begin
					if (sample_valid && cond_trace && !mfull_reg) begin
						wptr_reg  <= wptr_reg + 1'b1;
						mfull_reg <= (wptr_reg == LAST_IDX);
					end
					// stop wins over jump, jump over advance
					if (sample_valid && cond_stop) begin
						state_reg <= AAS_ST_XFER;
						ptr_reg   <= '0;
					end else if (sample_valid && cond_jump) begin
						level_reg <= jump_level;
					end else if (adv_cmd || (sample_valid && cond_advance)) begin
						if (level_reg == run_end_reg) begin
							state_reg <= AAS_ST_XFER;
							ptr_reg   <= '0;
						end else begin
							level_reg <= level_reg + 4'h1;
						end
					end
				end
				AAS_ST_XFER: begin
					ptr_reg <= ptr_reg + 1'b1;
					if (ptr_reg == LAST_IDX)
						state_reg <= halt_after_reg ? AAS_ST_IDLE : AAS_ST_POST;
				end
				AAS_ST_POST: begin
					// count is bumped this cycle; limit is seen in the decide step
					ptr_reg      <= run_lo_reg;
					mismatch_reg <= 1'b0;
					if (run_mode_reg == AAS_MANUAL)
						state_reg <= AAS_ST_IDLE;
					else if (is_cmp(run_mode_reg))
						state_reg <= AAS_ST_CMP;
					else
						state_reg <= AAS_ST_DECIDE;
				end
				AAS_ST_CMP: begin
					mismatch_reg <= mismatch_reg | last_diff;
					ptr_reg      <= ptr_reg + 1'b1;
					if (ptr_reg == run_hi_reg)
						state_reg <= AAS_ST_DECIDE;
				end
				AAS_ST_DECIDE: begin
					ptr_reg <= '0;
					if (limit_hit || (is_cmp(run_mode_reg) && cmp_hit))
						state_reg <= AAS_ST_IDLE;
					else
						state_reg <= AAS_ST_CLEAR;
				end
			endcase
		end
	end
	// trace memory and level tags: cleared on re-arm, filled while recording
	always_ff @(posedge clock) begin
		if (state_reg == AAS_ST_CLEAR) begin
			mem_m[ptr_reg]   <= '0;
			mem_lvl[ptr_reg] <= `AAS_LEVEL_FILL;
		end else if (state_reg == AAS_ST_REC && sample_valid && cond_trace && !mfull_reg) begin
			mem_m[wptr_reg]   <= sample_data;
			mem_lvl[wptr_reg] <= level_reg;
		end
	end
	// display memory A only changes by a transfer of M, which a stop or arm can cut short
	always_ff @(posedge clock) begin
		if (state_reg == AAS_ST_XFER)
			mem_a[ptr_reg] <= mem_m[ptr_reg];
	end
	// reference memory B: word writes from the bus, or a background copy of A
	always_ff @(posedge clock) begin
		if (apb_wr && paddr == `AAS_OFS_MDATA && msel_reg == AAS_SEL_B)
			mem_b[maddr_reg] <= pwdata[CH-1:0];
		else if (copy_busy_reg)
			mem_b[cptr_reg] <= mem_a[cptr_reg];
	end
	// copy of A into B; a bus write to B during the copy costs that one word
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			copy_busy_reg <= 1'b0;
			cptr_reg      <= '0;
		end else if (copy_busy_reg) begin
			cptr_reg <= cptr_reg + 1'b1;
			if (cptr_reg == LAST_IDX)
				copy_busy_reg <= 1'b0;
		end else if (cmd_wr && pwdata[`AAS_CMD_COPYAB]) begin
			copy_busy_reg <= 1'b1;
			cptr_reg      <= '0;
		end
	end
	// status pins, one cycle behind the sequencer state
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			level_out <= `AAS_LEVEL_FILL;
			busy_out  <= 1'b0;
			ready_out <= 1'b1;
		end else begin
			level_out <= level_reg;
			busy_out  <= (state_reg == AAS_ST_WAIT) || (state_reg == AAS_ST_REC);
			ready_out <= (state_reg == AAS_ST_IDLE);
		end
	end
endmodule

// ==== test/aas_seq_properties.sv ====
// concurrent checks on the ports of the arm sequencer
module aas_seq_properties (
	// clock and reset
	input wire logic        clock,
	input wire logic        rst_b,
	// register bus
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// trace side
	input wire logic        sample_valid,
	input wire logic [3:0]  level_out,
	input wire logic        busy_out,
	input wire logic        ready_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// one clock domain, so clocking and reset are given once
	default clocking @(posedge clock);
	endclocking
	default disable iff (!rst_b);

	wait_one_a: assert property (psel && penable && !pready |=> pready)
		else $error("no answer after one wait");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready held");
	ready_access_a: assert property (pready |-> psel && penable)
		else $error("pready outside access");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	err_align_a: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
		else $error("unaligned access not refused");
	err_range_a: assert property (pready && paddr > 8'h28 |-> pslverr)
		else $error("unmapped access not refused");
	err_data_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
		else $error("refused read not zero");
	ok_mapped_a: assert property (pready && paddr <= 8'h28 && paddr[1:0] == 2'h0 |-> !pslverr)
		else $error("mapped access refused");
	busy_ready_a: assert property (!(busy_out && ready_out))
		else $error("busy and ready together");
	// level_out trails the level by one cycle, so level 0 shows two edges after the sample
	level_zero_a: assert property (sample_valid && busy_out && level_out == 4'hF
		|-> ##2 level_out == 4'h0)
		else $error("first sample did not enter level 0");

	// main scenarios reached
	cover property (sample_valid && busy_out && level_out == 4'hF);
	cover property (pready && pslverr);
	cover property ($rose(ready_out));
endmodule

bind aas_acq_arm_seq aas_seq_properties u_props (
	.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.sample_valid(sample_valid), .level_out(level_out), .busy_out(busy_out),
	.ready_out(ready_out)
);

// ==== test/aas_target_model.sv ====
// target-side model: one burst of four samples per request
module aas_target_model (
	// clock and reset
	input  wire logic        clock,
	input  wire logic        rst_b,
	// burst request from the bench
	input  wire logic        go,
	// sampled target and level conditions
	output logic             sample_valid,
	output logic [31:0]      sample_data,
	output logic             cond_stop,
	output logic             cond_jump,
	output logic [3:0]       jump_level,
	output logic             cond_advance,
	output logic             cond_trace
);
	timeunit 1ns;
	timeprecision 1ps;
	// stop and jump never fire; passes end by advancing out of the end level
	assign cond_stop  = 1'b0;
	assign cond_jump  = 1'b0;
	assign jump_level = 4'h0;
	// data flips between samples so a stale read cannot pass for a fresh one
	initial begin
		sample_valid = 1'b0;
		sample_data  = 32'h0;
		cond_advance = 1'b0;
		cond_trace   = 1'b0;
		forever begin
			@(posedge clock);
			if (go && rst_b) begin
				for (int i = 0; i < 4; i++) begin
					sample_valid <= 1'b1;
					sample_data  <= 32'hA5A50000 + 32'(i);
					cond_trace   <= 1'b1;
					cond_advance <= (i == 3);
					@(posedge clock);
					sample_valid <= 1'b0;
					sample_data  <= ~(32'hA5A50000 + 32'(i));
					cond_trace   <= 1'b0;
					cond_advance <= 1'b0;
					@(posedge clock);
				end
			end
		end
	end
endmodule

// ==== test/aas_acq_arm_seq_bench.sv ====
// self-checking bench for the acquisition arm sequencer
`include "aas_regs.svh"
module aas_acq_arm_seq_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clock;
	logic        rst_b;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        sample_valid;
	logic [31:0] sample_data;
	logic        cond_stop;
	logic        cond_jump;
	logic [3:0]  jump_level;
	logic        cond_advance;
	logic        cond_trace;
	logic [3:0]  level_out;
	logic        busy_out;
	logic        ready_out;
	logic        go;
	logic [31:0] rd;
	logic        er;
	int          n_mismatch;
	int          samples_checked;
	int          cycles;

	// 8 ns clock
	always #4 clock = ~clock;

	aas_acq_arm_seq #(.CH(32), .AW(8), .DEPTH(256)) u_aas_acq_arm_seq (
		.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sample_valid(sample_valid), .sample_data(sample_data),
		.cond_stop(cond_stop), .cond_jump(cond_jump), .jump_level(jump_level),
		.cond_advance(cond_advance), .cond_trace(cond_trace), .level_out(level_out),
		.busy_out(busy_out), .ready_out(ready_out)
	);
	aas_target_model u_aas_target_model (
		.clock(clock), .rst_b(rst_b), .go(go), .sample_valid(sample_valid),
		.sample_data(sample_data), .cond_stop(cond_stop), .cond_jump(cond_jump),
		.jump_level(jump_level), .cond_advance(cond_advance), .cond_trace(cond_trace)
	);

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask
	// request held until pready is seen high at a rising edge
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(rd, e);
	endtask
	task automatic cmd(input int b);
		wr(`AAS_OFS_CMD, 32'h1 << b);
	endtask
	// long wait: transfer, compare and clear of the previous pass must be over
	task automatic pass();
		repeat (900) @(posedge clock);
		go <= 1'b1;
		@(posedge clock);
		go <= 1'b0;
		repeat (12) @(posedge clock);
	endtask
	task automatic wait_idle();
		int n;
		n = 0;
		do begin
			xfer(1'b0, `AAS_OFS_STATUS, 32'h0);
			n++;
		end while (rd[2] !== 1'b1 && n < 400);
		chk({31'h0, rd[2]}, 32'h1);
	endtask
	// arm, run passes, maybe stop by hand, then check the pass count
	task automatic run(input logic [31:0] c, input int p, input int s, input logic [31:0] e);
		wr(`AAS_OFS_CTRL, c);
		cmd(`AAS_CMD_ARM);
		repeat (p) pass();
		if (s != 0) begin
			repeat (900) @(posedge clock);
			cmd(s);
		end
		wait_idle();
		cmd(`AAS_CMD_SNAP);
		rdc(`AAS_OFS_PCOUNT, e);
		$display("test mode %0h done", c);
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// cycle ceiling cuts a hang short
	always @(posedge clock) begin
		cycles++;
		if (cycles == 60000) begin
			n_mismatch++;
			$display("[ERR] %0t timeout", $time);
			print_verdict();
		end
	end

	initial begin
		clock   = 1'b0;
		rst_b   = 1'b0;
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 8'h00;
		pwdata  = 32'h0;
		go      = 1'b0;
		repeat (2) @(posedge clock);
		rst_b <= 1'b1;
		rdc(`AAS_OFS_CTRL, 32'h000000F0);
		rdc(`AAS_OFS_STATUS, 32'h000000F4);
		chk({26'h0, level_out, busy_out, ready_out}, 32'h0000003D);
		rdc(`AAS_OFS_CHMASK, 32'hFFFFFFFF);
		xfer(1'b0, 8'h2C, 32'h0);
		chk({31'h0, er}, 32'h1);
		chk(rd, 32'h0);
		$display("test reset done");
		// manual pass to level 1, then the advance command leaves the end level
		wr(`AAS_OFS_CTRL, 32'h00000010);
		cmd(`AAS_CMD_ARM);
		repeat (300) @(posedge clock);
		wr(`AAS_OFS_MADDR, 32'h00000000);
		rdc(`AAS_OFS_MDATA, 32'h00000000);
		wr(`AAS_OFS_MADDR, 32'h00030007);
		rdc(`AAS_OFS_MDATA, 32'h0000000F);
		pass();
		rdc(`AAS_OFS_STATUS, 32'h00000012);
		chk({26'h0, level_out, busy_out, ready_out}, 32'h00000006);
		cmd(`AAS_CMD_ADVANCE);
		wait_idle();
		cmd(`AAS_CMD_SNAP);
		rdc(`AAS_OFS_PCOUNT, 32'h1);
		wr(`AAS_OFS_MADDR, 32'h00010000);
		rdc(`AAS_OFS_MDATA, 32'hA5A50001);
		wr(`AAS_OFS_MADDR, 32'h00010001);
		rdc(`AAS_OFS_MDATA, 32'hA5A50002);
		repeat (900) @(posedge clock);
		xfer(1'b0, `AAS_OFS_STATUS, 32'h0);
		chk({31'h0, rd[2]}, 32'h1);
		$display("test manual done");
		wr(`AAS_OFS_PLIMIT, 32'h2);
		wr(`AAS_OFS_PLIMIT, 32'h00002710);
		rdc(`AAS_OFS_PLIMIT, 32'h2);
		run(32'h01, 2, 0, 32'h2);
		cmd(`AAS_CMD_COPYAB);
		repeat (300) @(posedge clock);
		wr(`AAS_OFS_PLIMIT, 32'h0);
		wr(`AAS_OFS_TOD, 32'h00123456);
		run(32'h02, 1, 0, 32'h1);
		rdc(`AAS_OFS_ATIME, 32'h00123456);
		run(32'h03, 2, `AAS_CMD_MOVESTOP, 32'h2);
		run(32'h01, 1, `AAS_CMD_STOP, 32'h1);
		wr(`AAS_OFS_MADDR, 32'h00020005);
		wr(`AAS_OFS_MDATA, 32'h80000000);
		wr(`AAS_OFS_CURSOR, 32'h00030000);
		run(32'h04, 1, 0, 32'h1);
		wr(`AAS_OFS_CURSOR, 32'h00010003);
		wr(`AAS_OFS_CHMASK, 32'h7FFFFFFF);
		run(32'h04, 1, 0, 32'h1);
		wr(`AAS_OFS_CHMASK, 32'hFFFFFFFF);
		run(32'h05, 1, 0, 32'h1);
		run(32'h04, 2, `AAS_CMD_MOVESTOP, 32'h2);
		print_verdict();
	end
endmodule
